//--- include/art_pkg.sv
/*
  Package for the auto-reload PWM timer: register offsets, field layouts,
  mode encodings and reset values.
  Assumes an 8-bit data-space register bus with byte-wide registers.
*/
package art_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] ART_OFF_MODE_CONTROL = 8'hD5;
  localparam logic [7:0] ART_OFF_STATUS_FLAGS = 8'hD6;
  localparam logic [7:0] ART_OFF_CLOCK_PRESCALE_CONFIG = 8'hD7;
  localparam logic [7:0] ART_OFF_RELOAD_CAPTURE_VALUE = 8'hD9;
  localparam logic [7:0] ART_OFF_COMPARE_VALUE = 8'hDA;
  localparam logic [7:0] ART_OFF_COUNTER_ACCESS = 8'hDB;

  // ----------------------------------------------------------------------
  // Values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] ART_BYTE_ZERO = 8'h00;
  localparam logic [7:0] ART_COUNT_MAX = 8'hFF;
  localparam logic [6:0] ART_PSC_ZERO = 7'h00;
  localparam logic [1:0] ART_DIV3_LAST = 2'h2;
  localparam int ART_TRIG_BIT = 7;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ART_MODE_RELOAD = 2'h0,
    ART_MODE_CAPTURE = 2'h1,
    ART_MODE_CAPTURE_RESET = 2'h2,
    ART_MODE_EXT_LOAD = 2'h3
  } art_mode_t;

  typedef enum logic [1:0] {
    ART_SRC_INTERNAL = 2'h0,
    ART_SRC_INTERNAL_DIV3 = 2'h1,
    ART_SRC_PIN = 2'h2,
    ART_SRC_RESERVED = 2'h3
  } art_src_t;

  typedef struct packed {
    logic load_trigger;
    logic count_enable;
    logic wave_output_enable;
    logic edge_irq_enable;
    logic match_irq_enable;
    logic wrap_irq_enable;
    art_mode_t mode_sel;
  } art_mode_control_t;

  typedef struct packed {
    logic [2:0] prescale_sel;
    logic reserved;
    logic edge_polarity;
    logic edge_detect_enable;
    art_src_t clk_src;
  } art_config_t;

  typedef struct packed {
    logic edge_flag;
    logic match_flag;
    logic wrap_flag;
  } art_flags_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } art_bus_t;

  localparam art_mode_control_t ART_MODE_CONTROL_RESET = '{default: 1'b0, mode_sel: ART_MODE_RELOAD};
  localparam art_config_t ART_CONFIG_RESET = '{default: 1'b0, clk_src: ART_SRC_INTERNAL};
  localparam art_flags_t ART_FLAGS_RESET = 3'h0;

endpackage

//--- hw/art_timer.sv
/*
  Auto-reload 8-bit PWM timer with 7-bit prescaler, four modes, edge input,
  PWM output and three masked interrupt requests.
  Assumes a single 125 MHz core_clk, an asynchronous active-high rst and a
  bus master that pulses one strobe per cycle; the timer input pin is
  asynchronous and is synchronised here.
*/
// The strobed register port was left to the implementer.
// Overview of operation
// [R01] Reset clears mode control to zero
// [R02] Load trigger copies reload, clears prescaler; reads zero
// [R03] Count enable low freezes prescaler and counter
// [R04] Output enable gates PWM onto output pin
// [R05] Edge flag and enable raise request
// [R06] Match flag and enable raise request
// [R07] Wrap flag and enable raise request
// [R08] Mode field selects one of four modes
// [R09] Writing zero clears flag, one keeps it
// [R10] Enabled active input edge sets edge flag
// [R11] Counter equal to compare sets match flag
// [R12] Wrap from FF to 00 sets flag
// [R13] Prescale ratio two to field; count undisturbed
// [R14] Software writes zero to reserved bit
// [R15] Edge enable bit and polarity select edge
// [R16] Clock source: internal, divide three, pin
// [R17] Load register accesses running counter; reset-free
// [R18] Auto-reload mode reloads counter on overflow
// [R19] Overflow drives output high, match low
// [R20] Capture mode copies counter on edge
// [R21] Capture-reset mode also clears counter, prescaler
// [R22] External-load mode loads counter on edge
// [R23] Input pin synchronised, edges from previous sample
// [R24] Counter increments on prescaler output pulse
`timescale 1ns/10ps
module art_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire art_pkg::art_bus_t bus,
  output logic [7:0] rd_data,
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  output logic edge_irq,
  output logic match_irq,
  output logic wrap_irq
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  art_pkg::art_mode_control_t mode_control_reg;
  art_pkg::art_config_t clock_prescale_config_reg;
  art_pkg::art_flags_t status_flags_reg;
  art_pkg::art_flags_t status_flags_next;
  logic [7:0] reload_capture_value_reg;
  logic [7:0] compare_value_reg;
  logic [7:0] counter_access_reg;
  logic [7:0] main_counter_reg;
  logic [7:0] main_counter_next;
  logic [6:0] prescaler_count_reg;
  logic [6:0] prescaler_count_next;
  logic [1:0] div3_reg;
  logic sync1_reg;
  logic sync2_reg;
  logic prev_reg;
  logic wave_reg;
  logic [7:0] rd_data_reg;

  logic wr_mode;
  logic wr_status;
  logic wr_config;
  logic wr_reload;
  logic wr_compare;
  logic wr_counter;
  logic trig_load;
  logic pin_rise;
  logic pin_fall;
  logic edge_evt;
  logic div3_tick;
  logic src_tick;
  logic psc_hit;
  logic inc;
  logic edge_capture;
  logic edge_clear;
  logic edge_load;
  logic load_evt;
  logic cnt_change;
  logic wrap_evt;
  logic match_evt;

  function automatic logic [6:0] psc_mask(input logic [2:0] sel);
    logic [7:0] one_hot;
    one_hot = 8'h01 << sel;
    return 7'(one_hot - 8'h01);
  endfunction

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  assign wr_mode = bus.wr && (bus.addr == art_pkg::ART_OFF_MODE_CONTROL);
  assign wr_status = bus.wr && (bus.addr == art_pkg::ART_OFF_STATUS_FLAGS);
  assign wr_config = bus.wr && (bus.addr == art_pkg::ART_OFF_CLOCK_PRESCALE_CONFIG);
  assign wr_reload = bus.wr && (bus.addr == art_pkg::ART_OFF_RELOAD_CAPTURE_VALUE);
  assign wr_compare = bus.wr && (bus.addr == art_pkg::ART_OFF_COMPARE_VALUE);
  assign wr_counter = bus.wr && (bus.addr == art_pkg::ART_OFF_COUNTER_ACCESS);
  assign trig_load = wr_mode && bus.wdata[art_pkg::ART_TRIG_BIT]; // R02

  // ----------------------------------------------------------------------
  // Input pin synchroniser and edge detect
  // ----------------------------------------------------------------------
  // First stage feeds only the second, so metastability stays contained.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      sync1_reg <= timer_input_pin; // R23
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign pin_rise = sync2_reg && !prev_reg; // R23
  assign pin_fall = !sync2_reg && prev_reg;
  assign edge_evt = clock_prescale_config_reg.edge_detect_enable &&
                    (clock_prescale_config_reg.edge_polarity ? pin_fall : pin_rise); // R15

  // ----------------------------------------------------------------------
  // Clock source and prescaler
  // ----------------------------------------------------------------------
  // Divide-by-three runs free so that a source switch never stalls it.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      div3_reg <= 2'h0;
    end else if (div3_reg == art_pkg::ART_DIV3_LAST) begin
      div3_reg <= 2'h0;
    end else begin
      div3_reg <= div3_reg + 2'h1;
    end
  end

  assign div3_tick = (div3_reg == art_pkg::ART_DIV3_LAST);

  always_comb begin
    unique case (clock_prescale_config_reg.clk_src) // R16
      art_pkg::ART_SRC_INTERNAL: src_tick = 1'b1;
      art_pkg::ART_SRC_INTERNAL_DIV3: src_tick = div3_tick;
      art_pkg::ART_SRC_PIN: src_tick = pin_rise;
      art_pkg::ART_SRC_RESERVED: src_tick = 1'b0;
    endcase
  end

  // Ratio follows the field at once; the count itself is not touched.
  assign psc_hit = (prescaler_count_reg & psc_mask(clock_prescale_config_reg.prescale_sel)) ==
                   psc_mask(clock_prescale_config_reg.prescale_sel); // R13

  // ----------------------------------------------------------------------
  // Counter events
  // ----------------------------------------------------------------------
  assign edge_capture = edge_evt && (mode_control_reg.mode_sel == art_pkg::ART_MODE_CAPTURE ||
                                     mode_control_reg.mode_sel == art_pkg::ART_MODE_CAPTURE_RESET); // R20
  assign edge_clear = edge_evt && (mode_control_reg.mode_sel == art_pkg::ART_MODE_CAPTURE_RESET); // R21
  assign edge_load = edge_evt && (mode_control_reg.mode_sel == art_pkg::ART_MODE_EXT_LOAD); // R22
  assign load_evt = wr_counter || trig_load || edge_clear || edge_load;
  assign inc = mode_control_reg.count_enable && src_tick && psc_hit && !load_evt; // R03 R24
  assign wrap_evt = inc && (main_counter_reg == art_pkg::ART_COUNT_MAX); // R12
  assign cnt_change = load_evt || inc;
  assign match_evt = cnt_change && (main_counter_next == compare_value_reg); // R11

  // Software loads beat trigger, trigger beats input edge, edges beat counting.
  always_comb begin
    main_counter_next = main_counter_reg;
    prescaler_count_next = prescaler_count_reg;
    if (wr_counter) begin
      main_counter_next = bus.wdata; // R17
      prescaler_count_next = art_pkg::ART_PSC_ZERO;
    end else if (trig_load) begin
      main_counter_next = reload_capture_value_reg; // R02
      prescaler_count_next = art_pkg::ART_PSC_ZERO;
    end else if (edge_clear) begin
      main_counter_next = art_pkg::ART_BYTE_ZERO; // R21
      prescaler_count_next = art_pkg::ART_PSC_ZERO;
    end else if (edge_load) begin
      main_counter_next = reload_capture_value_reg; // R22
      prescaler_count_next = art_pkg::ART_PSC_ZERO;
    end else if (wrap_evt && mode_control_reg.mode_sel == art_pkg::ART_MODE_RELOAD) begin
      main_counter_next = reload_capture_value_reg; // R18
      prescaler_count_next = art_pkg::ART_PSC_ZERO;
    end else if (inc) begin
      main_counter_next = main_counter_reg + 8'h01; // R24
      prescaler_count_next = prescaler_count_reg + 7'h01;
    end else if (mode_control_reg.count_enable && src_tick) begin
      prescaler_count_next = prescaler_count_reg + 7'h01; // R03
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      main_counter_reg <= art_pkg::ART_BYTE_ZERO;
      prescaler_count_reg <= art_pkg::ART_PSC_ZERO;
    end else begin
      main_counter_reg <= main_counter_next;
      prescaler_count_reg <= prescaler_count_next;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  // The trigger bit is never stored, so it cannot read back as one.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_control_reg <= art_pkg::ART_MODE_CONTROL_RESET; // R01
    end else if (wr_mode) begin
      mode_control_reg <= art_pkg::art_mode_control_t'({1'b0, bus.wdata[6:0]}); // R02 R08
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      clock_prescale_config_reg <= art_pkg::ART_CONFIG_RESET;
    end else if (wr_config) begin
      clock_prescale_config_reg <= art_pkg::art_config_t'(bus.wdata);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      compare_value_reg <= art_pkg::ART_BYTE_ZERO;
    end else if (wr_compare) begin
      compare_value_reg <= bus.wdata;
    end
  end

  // A capture in the same cycle as a write wins: the event must not be lost.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reload_capture_value_reg <= art_pkg::ART_BYTE_ZERO;
    end else if (edge_capture) begin
      reload_capture_value_reg <= main_counter_reg; // R20
    end else if (wr_reload) begin
      reload_capture_value_reg <= bus.wdata;
    end
  end

  // Holds the last value written; left alone by reset.
  always_ff @(posedge core_clk) begin
    if (wr_counter) begin
      counter_access_reg <= bus.wdata; // R17
    end
  end

  // ----------------------------------------------------------------------
  // Flags and interrupt requests
  // ----------------------------------------------------------------------
  always_comb begin
    status_flags_next = status_flags_reg;
    if (wr_status) begin
      status_flags_next = status_flags_reg & art_pkg::art_flags_t'(bus.wdata[2:0]); // R09
    end
    if (edge_evt) begin
      status_flags_next.edge_flag = 1'b1; // R10
    end
    if (match_evt) begin
      status_flags_next.match_flag = 1'b1; // R11
    end
    if (wrap_evt) begin
      status_flags_next.wrap_flag = 1'b1; // R12
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_flags_reg <= art_pkg::ART_FLAGS_RESET;
    end else begin
      status_flags_reg <= status_flags_next;
    end
  end

  assign edge_irq = status_flags_reg.edge_flag && mode_control_reg.edge_irq_enable; // R05
  assign match_irq = status_flags_reg.match_flag && mode_control_reg.match_irq_enable; // R06
  assign wrap_irq = status_flags_reg.wrap_flag && mode_control_reg.wrap_irq_enable; // R07

  // ----------------------------------------------------------------------
  // PWM output
  // ----------------------------------------------------------------------
  // Match wins a tie, so a compare equal to the reload gives a low output.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wave_reg <= 1'b0;
    end else if (match_evt) begin
      wave_reg <= 1'b0; // R19
    end else if (wrap_evt) begin
      wave_reg <= 1'b1; // R19
    end
  end

  assign timer_output_pin = wave_reg && mode_control_reg.wave_output_enable; // R04

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= art_pkg::ART_BYTE_ZERO;
    end else if (bus.rd) begin
      unique case (bus.addr)
        art_pkg::ART_OFF_MODE_CONTROL: rd_data_reg <= {1'b0, mode_control_reg[6:0]}; // R02
        art_pkg::ART_OFF_STATUS_FLAGS: rd_data_reg <= {5'h00, status_flags_reg};
        art_pkg::ART_OFF_CLOCK_PRESCALE_CONFIG: rd_data_reg <= clock_prescale_config_reg;
        art_pkg::ART_OFF_RELOAD_CAPTURE_VALUE: rd_data_reg <= reload_capture_value_reg;
        art_pkg::ART_OFF_COMPARE_VALUE: rd_data_reg <= compare_value_reg;
        art_pkg::ART_OFF_COUNTER_ACCESS: rd_data_reg <= main_counter_reg; // R17
        default: rd_data_reg <= art_pkg::ART_BYTE_ZERO;
      endcase
    end else begin
      rd_data_reg <= art_pkg::ART_BYTE_ZERO;
    end
  end

  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  trig_reads_zero_a: assert property (bus.rd && bus.addr == art_pkg::ART_OFF_MODE_CONTROL |=> !rd_data[7]) // R02
    else $error("load trigger bit read back as one");
  trig_load_a: assert property (trig_load |=> main_counter_reg == $past(reload_capture_value_reg) &&
                                prescaler_count_reg == art_pkg::ART_PSC_ZERO) // R02
    else $error("load trigger did not load counter");
  freeze_hold_a: assert property (!mode_control_reg.count_enable && !bus.wr && !edge_clear && !edge_load
                                  |=> $stable(main_counter_reg) && $stable(prescaler_count_reg)) // R03
    else $error("counter moved while disabled");
  out_gate_a: assert property (!mode_control_reg.wave_output_enable |-> !timer_output_pin) // R04
    else $error("PWM output active while disabled");
  edge_irq_a: assert property (edge_evt && mode_control_reg.edge_irq_enable && !wr_mode |=> edge_irq) // R05 R10
    else $error("edge request missing");
  match_irq_a: assert property (match_evt && mode_control_reg.match_irq_enable && !wr_mode |=> match_irq) // R06 R11
    else $error("match request missing");
  wrap_irq_a: assert property (wrap_evt && mode_control_reg.wrap_irq_enable && !wr_mode |=> wrap_irq) // R07 R12
    else $error("wrap request missing");
  flag_keep_a: assert property (wr_status && bus.wdata[0] && status_flags_reg.wrap_flag |=>
                                status_flags_reg.wrap_flag) // R09
    else $error("writing one cleared a flag");
  reload_wrap_a: assert property (wrap_evt && mode_control_reg.mode_sel == art_pkg::ART_MODE_RELOAD
                                  |=> main_counter_reg == $past(reload_capture_value_reg)) // R18
    else $error("auto-reload missed");
  capture_a: assert property (edge_capture |=> reload_capture_value_reg == $past(main_counter_reg)) // R20
    else $error("capture value wrong");
  cap_reset_a: assert property (edge_clear && !wr_counter && !trig_load |=>
                                main_counter_reg == art_pkg::ART_BYTE_ZERO) // R21
    else $error("capture did not clear counter");
  ext_load_a: assert property (edge_load && !wr_counter && !trig_load |=>
                               main_counter_reg == $past(reload_capture_value_reg)) // R22
    else $error("edge load missed");
  pwm_high_a: assert property (wrap_evt && !match_evt |=> wave_reg ##1 (wave_reg || $past(match_evt))) // R19
    else $error("overflow did not raise output");
  pwm_low_a: assert property (match_evt |=> !wave_reg) // R19
    else $error("match did not lower output");
  count_step_a: assert property (inc && !wrap_evt |=> main_counter_reg == $past(main_counter_reg) + 8'h01) // R24
    else $error("counter did not step by one");
  src_reserved_a: assert property (clock_prescale_config_reg.clk_src == art_pkg::ART_SRC_RESERVED && !load_evt
                                   |=> $stable(main_counter_reg)) // R16
    else $error("counter moved on reserved source");
  load_mirror_a: assert property (wr_counter |=> main_counter_reg == counter_access_reg) // R17
    else $error("load register and counter disagree");
  flag_clear_a: assert property (wr_status && !bus.wdata[0] && !wrap_evt |=> !status_flags_reg.wrap_flag) // R09
    else $error("writing zero did not clear flag");

  wrap_seen_c: cover property (wrap_evt ##[1:300] match_evt);
  capture_seen_c: cover property (edge_capture);
  ext_load_seen_c: cover property (edge_load && !mode_control_reg.count_enable);
  flag_race_c: cover property (wr_status && !bus.wdata[2] && edge_evt);

endmodule

//--- verif/art_pin_drv.sv
/*
  Far-side model of the timer input pin: a source that moves the pin
  one level at a time.
  Assumes the bench calls drive() from its main sequence on core_clk.
*/
`timescale 1ns/10ps
module art_pin_drv (
  input wire logic core_clk,
  output logic pin
);
  // ----------------------------------------------------------------------
  // Level driver
  // ----------------------------------------------------------------------
  initial pin = 1'b0;

  // Hold each level four cycles so the two-flop sampler always sees it
  task automatic drive(input logic lvl);
    @(posedge core_clk);
    pin <= lvl;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

//--- verif/tb.sv
/*
  Self-checking bench for the auto-reload PWM timer: register tasks on the
  byte bus, a pin source model and directed mode sequences.
  Assumes the art_pkg package and the art_timer top module.
*/
`timescale 1ns/10ps
module tb;
  logic core_clk;
  logic rst;
  art_pkg::art_bus_t bus;
  logic [7:0] rd_data;
  logic pin;
  logic out_pin;
  logic edge_irq;
  logic match_irq;
  logic wrap_irq;
  int err_total;
  int comparisons;
  int n;
  logic [7:0] v1;
  logic [7:0] v2;

  art_timer dut (
    .core_clk(core_clk),
    .rst(rst),
    .bus(bus),
    .rd_data(rd_data),
    .timer_input_pin(pin),
    .timer_output_pin(out_pin),
    .edge_irq(edge_irq),
    .match_irq(match_irq),
    .wrap_irq(wrap_irq)
  );
  art_pin_drv pdrv (
    .core_clk(core_clk),
    .pin(pin)
  );

  always #4 core_clk = ~core_clk;

  // ----------------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    if (err_total == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %02X seen %02X", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
    // Let the write settle so a check right after sees the new register state
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    v = rd_data;
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(name, v, exp);
  endtask

  // Counts edges until the chosen request is high; running out is a failure
  task automatic wait_irq(input int which, input int limit, output int cnt);
    logic s;
    cnt = 0;
    s = 1'b0;
    while (s !== 1'b1) begin
      @(posedge core_clk);
      #1;
      cnt++;
      s = (which == 0) ? wrap_irq : (which == 1) ? match_irq : edge_irq;
      if (cnt > limit) begin
        err_total++;
        $display("CHECK FAILED wait_irq expected 01 seen 00");
        end_sim();
      end
    end
  endtask

  task automatic cnt_delta(input int gap, input logic [7:0] exp, input string name);
    rd(8'hDB, v1);
    repeat (gap - 2) @(posedge core_clk);
    rd(8'hDB, v2);
    chk(name, v2 - v1, exp);
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    rst = 1'b1;
    bus = '0;
    err_total = 0;
    comparisons = 0;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    rdc("mode_control", 8'hD5, 8'h00);
    rdc("status_flags", 8'hD6, 8'h00);
    rdc("counter_access", 8'hDB, 8'h00);
    wr(8'hD8, 8'hFF);
    rdc("unmapped", 8'hD8, 8'h00);
    wr(8'hD7, 8'hE5);
    rdc("clock_prescale_config", 8'hD7, 8'hE5);
    wr(8'hDB, 8'h33);
    repeat (10) @(posedge core_clk);
    rdc("frozen counter", 8'hDB, 8'h33);
    wr(8'hD9, 8'h40);
    wr(8'hD5, 8'h80);
    rdc("triggered counter", 8'hDB, 8'h40);
    rdc("trigger readback", 8'hD5, 8'h00);
    // Auto-reload with PWM, ratio one
    wr(8'hD7, 8'h00);
    wr(8'hDA, 8'h80);
    wr(8'hDB, 8'hF0);
    wr(8'hD5, 8'h6C);
    wait_irq(0, 40, n);
    chk("pin after wrap", {7'h00, out_pin}, 8'h01);
    wait_irq(1, 100, n);
    chk("reload to match", n[7:0], 8'h40);
    chk("pin after match", {7'h00, out_pin}, 8'h00);
    rdc("both flags", 8'hD6, 8'h03);
    wr(8'hD6, 8'h06);
    rdc("wrap cleared", 8'hD6, 8'h02);
    chk("wrap request", {7'h00, wrap_irq}, 8'h00);
    wr(8'hD5, 8'h64);
    chk("match masked", {7'h00, match_irq}, 8'h00);
    wait_irq(0, 260, n);
    wr(8'hD5, 8'h44);
    chk("output gated", {7'h00, out_pin}, 8'h00);
    wr(8'hD5, 8'h64);
    chk("output enabled", {7'h00, out_pin}, 8'h01);
    // Prescale and clock sources
    wr(8'hD7, 8'h60);
    cnt_delta(64, 8'h08, "ratio eight");
    wr(8'hD7, 8'h01);
    cnt_delta(60, 8'h14, "divide by three");
    wr(8'hD7, 8'h03);
    cnt_delta(20, 8'h00, "reserved source");
    wr(8'hD7, 8'h02);
    rd(8'hDB, v1);
    for (int i = 0; i < 3; i++) begin
      pdrv.drive(1'b1);
      pdrv.drive(1'b0);
    end
    rd(8'hDB, v2);
    chk("pin source", v2 - v1, 8'h03);
    // Edge modes with the counter stopped
    wr(8'hD5, 8'h00);
    wr(8'hD6, 8'h00);
    wr(8'hDB, 8'h5A);
    wr(8'hD7, 8'h04);
    wr(8'hD5, 8'h11);
    pdrv.drive(1'b1);
    wait_irq(2, 6, n);
    rdc("capture", 8'hD9, 8'h5A);
    wr(8'hD6, 8'h03);
    rdc("edge cleared", 8'hD6, 8'h00);
    chk("edge request", {7'h00, edge_irq}, 8'h00);
    pdrv.drive(1'b0);
    rdc("wrong edge", 8'hD6, 8'h00);
    wr(8'hD7, 8'h0C);
    pdrv.drive(1'b1);
    pdrv.drive(1'b0);
    rdc("falling edge", 8'hD6, 8'h04);
    wr(8'hD6, 8'h03);
    wr(8'hD7, 8'h08);
    pdrv.drive(1'b1);
    pdrv.drive(1'b0);
    rdc("detect off", 8'hD6, 8'h00);
    wr(8'hD7, 8'h04);
    wr(8'hDB, 8'h77);
    wr(8'hD5, 8'h12);
    pdrv.drive(1'b1);
    rdc("capture reset value", 8'hD9, 8'h77);
    rdc("capture reset counter", 8'hDB, 8'h00);
    pdrv.drive(1'b0);
    wr(8'hD9, 8'h99);
    wr(8'hDB, 8'h11);
    wr(8'hD5, 8'h13);
    pdrv.drive(1'b1);
    rdc("edge load", 8'hDB, 8'h99);
    end_sim();
  end
endmodule
